/* File: sram_area_pkg.sv */
// Shared constants and carriers for the SRAM area wait controller
package sram_area_pkg;

  localparam int APB_ADDR_W = 12;
  localparam int MEM_ADDR_W = 24;
  localparam int LANES = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [APB_ADDR_W-1:0] OFS_WAIT_CTRL = 12'h000;
  localparam logic [APB_ADDR_W-1:0] OFS_IF_CFG = 12'h004;
  localparam logic [APB_ADDR_W-1:0] OFS_STATUS = 12'h008;

  ////////////////////////////////////////////////////////////////////////////
  // Wait control fields
  localparam int BAS_BIT = 20;
  localparam int WW_LSB = 16;
  localparam int SW_LSB = 11;
  localparam int WR_LSB = 7;
  localparam int WM_BIT = 6;
  localparam logic [31:0] WAIT_CTRL_MASK = 32'h0017_1fc0;
  localparam logic [31:0] WAIT_CTRL_RESET = 32'h0000_0500;
  localparam logic IF_CFG_RESET = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Read wait table, prohibited codes fall back to the longest
  localparam logic [15:0][4:0] READ_WAIT_TABLE = {
    5'h18, 5'h18, 5'h18, 5'h18, 5'h12, 5'h0e, 5'h0c, 5'h0a,
    5'h08, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
  localparam logic [5:0] EXT_WAIT_EXTEND = 6'h01;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } ctl_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [MEM_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [LANES-1:0] be;
  } req_t;

  typedef struct packed {
    logic bus_clk;
    logic area_select_n;
    logic read_strobe_n;
    logic rd_wr_n;
    logic [LANES-1:0] byte_lane_strobe_n;
    logic [MEM_ADDR_W-1:0] addr;
    logic [31:0] data_out;
    logic data_oe;
  } pins_t;

endpackage

/* File: area_wait_decode.sv */
// Decodes read and write wait codes into bus cycle counts
`timescale 1ns/1ps
`default_nettype none
module area_wait_decode
  import sram_area_pkg::*;
(
  input wire logic [3:0] read_code,
  input wire logic [2:0] write_code,
  output logic [4:0] read_wait,
  output logic [4:0] write_wait
);

  always_comb begin
    read_wait = READ_WAIT_TABLE[read_code];
    write_wait = {2'h0, write_code - 3'h1};
    if (write_code == 3'h0) begin
      write_wait = read_wait;
    end
  end

endmodule
`default_nettype wire

/* File: sram_area_ctrl.sv */
// APB slave and strobe timing for one SRAM chip-select area
//
// Functional notes
// - Unused wait control bits 31-21, 19, 15-13, 5-0 always read zero.
// - Select clear: byte strobes pulse, direction line low whole write.
// - Select set: byte strobes low whole cycle, direction line pulses.
// - Byte access select acts only in byte-selection SRAM mode.
// - Write wait codes 1 to 7 give 0 to 6 wait cycles.
// - Write wait code zero reuses the read wait count.
// - Setup field gives 0.5, 1.5, 2.5, 3.5 bus cycles to strobes.
// - Read wait codes map to 0-6, 8, 10, 12, 14, 18, 24 cycles.
// - External wait honoured when mask clear, even with zero waits.
`timescale 1ns/1ps
`default_nettype none
module sram_area_ctrl
  import sram_area_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire req_t req,
  output logic req_busy,
  output logic req_done,
  output logic [31:0] req_rdata,
  output var pins_t mem_pins,
  input wire logic [31:0] mem_data_in,
  input wire logic ext_wait_n
);

  typedef struct packed {
    ctl_state_t st;
    logic phase;
    logic [5:0] cnt;
    logic [1:0] wait_sync;
    logic [31:0] din1;
    logic [31:0] din2;
    logic [31:0] wait_ctrl;
    logic byte_sram;
    logic mode;
    logic wm;
    logic is_write;
    logic [1:0] sw;
    logic [LANES-1:0] be;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    pins_t pins;
    logic [31:0] rdata;
    logic done;
    logic busy;
  } state_t;

  state_t r, n;
  logic [4:0] read_wait, write_wait, sel_wait;
  logic acc, take;

  function automatic logic mapped(input logic [APB_ADDR_W-1:0] a);
    mapped = (a == OFS_WAIT_CTRL) || (a == OFS_IF_CFG) || (a == OFS_STATUS);
  endfunction

  area_wait_decode u_decode (
    .read_code(r.wait_ctrl[WR_LSB +: 4]),
    .write_code(r.wait_ctrl[WW_LSB +: 3]),
    .read_wait(read_wait),
    .write_wait(write_wait)
  );

  assign acc = psel && penable;
  assign sel_wait = r.is_write ? write_wait : read_wait;
  assign take = req.valid && r.st == ST_IDLE && !r.phase && !r.done;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = r;
    n.phase = ~r.phase;
    n.pins.bus_clk = ~r.phase;
    n.done = 1'b0;
    n.wait_sync = {r.wait_sync[0], ext_wait_n};
    n.din1 = mem_data_in;
    n.din2 = r.din1;
    // APB access answered one cycle after it opens
    n.pready = acc && !r.pready;
    n.pslverr = 1'b0;
    if (acc && !r.pready) begin
      n.pslverr = !mapped(paddr);
      n.prdata = 32'h0;
      if (paddr == OFS_WAIT_CTRL) begin
        n.prdata = r.wait_ctrl & WAIT_CTRL_MASK;
      end else if (paddr == OFS_IF_CFG) begin
        n.prdata = {31'h0, r.byte_sram};
      end else if (paddr == OFS_STATUS) begin
        n.prdata = {29'h0, r.wait_sync[1], r.mode, r.busy};
      end
    end
    if (acc && r.pready && pwrite) begin
      if (paddr == OFS_WAIT_CTRL) begin
        n.wait_ctrl = pwdata & WAIT_CTRL_MASK;
      end else if (paddr == OFS_IF_CFG) begin
        n.byte_sram = pwdata[0];
      end
    end
    case (r.st)
      ST_IDLE: begin
        if (take) begin
          n.st = ST_SETUP;
          n.busy = 1'b1;
          n.is_write = req.write;
          n.be = req.be;
          // select only honoured in byte SRAM mode
          n.mode = r.byte_sram && r.wait_ctrl[BAS_BIT];
          n.wm = r.wait_ctrl[WM_BIT];
          n.sw = r.wait_ctrl[SW_LSB +: 2];
          n.cnt = {3'h0, r.wait_ctrl[SW_LSB +: 2], 1'b0};
          n.pins.area_select_n = 1'b0;
          n.pins.addr = req.addr;
          n.pins.data_out = req.wdata;
          n.pins.data_oe = req.write;
          // direction low for the whole write when mode is clear
          n.pins.rd_wr_n = !(req.write && !n.mode);
          n.pins.byte_lane_strobe_n = n.mode ? ~req.be : {LANES{1'b1}};
        end
      end
      ST_SETUP: begin
        if (r.cnt == 6'h0) begin
          // odd half cycle count lands on falling edge
          n.st = ST_STROBE;
          n.cnt = {sel_wait, 1'b1};
          n.pins.read_strobe_n = r.is_write;
          // byte strobes pulse as timing strobes
          if (!r.mode && (r.is_write || r.byte_sram)) begin
            n.pins.byte_lane_strobe_n = ~r.be;
          end
          // direction line pulses as write strobe
          if (r.mode && r.is_write) begin
            n.pins.rd_wr_n = 1'b0;
          end
        end else begin
          n.cnt = r.cnt - 6'h1;
        end
      end
      ST_STROBE: begin
        if (r.cnt != 6'h0) begin
          n.cnt = r.cnt - 6'h1;
        end else if (!r.wm && !r.wait_sync[1]) begin
          // external wait extends by one bus cycle
          n.cnt = EXT_WAIT_EXTEND;
        end else begin
          n.st = ST_HOLD;
          n.pins.read_strobe_n = 1'b1;
          if (!r.mode) begin
            n.pins.byte_lane_strobe_n = {LANES{1'b1}};
          end else begin
            n.pins.rd_wr_n = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        n.st = ST_IDLE;
        // Data sampled while the strobe was still low
        if (!r.is_write) begin
          n.rdata = r.din2;
        end
        n.done = 1'b1;
        n.busy = 1'b0;
        n.pins.area_select_n = 1'b1;
        n.pins.rd_wr_n = 1'b1;
        n.pins.byte_lane_strobe_n = {LANES{1'b1}};
        n.pins.data_oe = 1'b0;
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.wait_ctrl <= WAIT_CTRL_RESET;
      r.byte_sram <= IF_CFG_RESET;
      r.wait_sync <= 2'h3;
      r.pins.area_select_n <= 1'b1;
      r.pins.read_strobe_n <= 1'b1;
      r.pins.rd_wr_n <= 1'b1;
      r.pins.byte_lane_strobe_n <= {LANES{1'b1}};
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign req_busy = r.busy;
  assign req_done = r.done;
  assign req_rdata = r.rdata;
  assign mem_pins = r.pins;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [6:0] cs_age, strobe_age;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_age <= 7'h0;
      strobe_age <= 7'h0;
    end else begin
      cs_age <= (r.st == ST_IDLE) ? 7'h0 : cs_age + 7'h1;
      strobe_age <= (r.st == ST_STROBE) ? strobe_age + 7'h1 : 7'h0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  reserved_read_zero_a: assert property (
    pready && paddr == OFS_WAIT_CTRL |-> (prdata & ~WAIT_CTRL_MASK) == 32'h0)
    else $error("reserved bits read nonzero");
  status_dir_low_a: assert property (
    r.st != ST_IDLE && r.is_write && !r.mode |-> !r.pins.rd_wr_n)
    else $error("direction line not held for write");
  status_lanes_low_a: assert property (
    r.st != ST_IDLE && r.mode |-> r.pins.byte_lane_strobe_n == ~r.be)
    else $error("byte strobes not held as status");
  mode_gate_a: assert property (
    $rose(r.busy) |-> r.mode == ($past(r.byte_sram) && $past(r.wait_ctrl[BAS_BIT])))
    else $error("strobe mode not gated by interface type");
  setup_delay_a: assert property (
    r.st == ST_STROBE && $past(r.st) == ST_SETUP
      |-> cs_age == {4'h0, r.sw, 1'b1})
    else $error("setup delay wrong");
  write_wait_a: assert property (
    r.wait_ctrl[WW_LSB +: 3] != 3'h0
      |-> write_wait == {2'h0, r.wait_ctrl[WW_LSB +: 3] - 3'h1})
    else $error("write wait decode wrong");
  reuse_read_a: assert property (
    r.wait_ctrl[WW_LSB +: 3] == 3'h0 |-> write_wait == read_wait)
    else $error("write wait does not reuse read wait");
  read_table_a: assert property (
    r.wait_ctrl[WR_LSB +: 4] == 4'hb |-> read_wait == 5'h12)
    else $error("read wait decode wrong");
  ext_wait_a: assert property (
    r.st == ST_STROBE && r.cnt == 6'h0 && !r.wm && !r.wait_sync[1]
      |=> (r.st == ST_STROBE) [*2])
    else $error("external wait not honoured");
  strobe_len_a: assert property (
    r.st == ST_HOLD && $past(r.st) == ST_STROBE && r.wm
      |-> strobe_age == {1'b0, sel_wait, 1'b0} + 7'h2)
    else $error("strobe length wrong");
  opposite_edge_a: assert property (
    $fell(r.pins.read_strobe_n) |-> !r.phase && !r.pins.bus_clk)
    else $error("strobe not on opposite edge");

endmodule
`default_nettype wire

/* File: sram_model.sv */
// Behavioural SRAM on the far side of the area controller
`timescale 1ns/1ps
`default_nettype none
module sram_model
  import sram_area_pkg::*;
(
  input wire logic pclk,
  input wire pins_t pins,
  input wire logic stall,
  output logic [31:0] rdata,
  output logic wait_n
);
  logic [31:0] mem [64] = '{default: '0};
  logic [31:0] junk = 32'h5a5a_a5a5;
  int hold = 0;
  wire logic sel = !pins.area_select_n;
  wire logic [5:0] a = pins.addr[5:0];
  // Undriven data bus toggles every cycle
  assign rdata = (sel && !pins.read_strobe_n) ? mem[a] : junk;
  assign wait_n = !(stall && sel && hold < 6);
  always @(posedge pclk) begin
    junk <= ~junk;
    hold <= sel ? hold + 1 : 0;
    for (int l = 0; l < LANES; l++)
      if (sel && !pins.rd_wr_n && pins.data_oe && !pins.byte_lane_strobe_n[l])
        mem[a][8*l +: 8] <= pins.data_out[8*l +: 8];
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the SRAM area controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t got %0h want %0h", $time, a, b); end end
module testbench
  import sram_area_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic stall = 0, clr = 0, pready, pslverr, req_busy, req_done, ext_wait_n;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, req_rdata, mem_data_in, rd, rdat, dt;
  logic [31:0] x = 32'h35b6;
  logic [31:0] shadow [64] = '{default: '0};
  logic er, bm, byte_access_strobe_select;
  logic [1:0] sw;
  logic [2:0] ww;
  logic [3:0] wr, be;
  logic [5:0] ad;
  req_t req = '0;
  pins_t mem_pins;
  int fails = 0, total_checks = 0, c_sel, c_rd, c_rw, c_be, p_rd, p_be;

  always #20 pclk = ~pclk;

  sram_area_ctrl i_sram_area_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req(req), .req_busy(req_busy), .req_done(req_done),
    .req_rdata(req_rdata), .mem_pins(mem_pins),
    .mem_data_in(mem_data_in), .ext_wait_n(ext_wait_n));
  sram_model i_sram_model (.pclk(pclk), .pins(mem_pins), .stall(stall),
    .rdata(mem_data_in), .wait_n(ext_wait_n));

  ////////////////////////////////////////////////////////////////////////////
  // Pin monitor: low counts and setup lengths
  always @(posedge pclk) begin
    if (clr) begin
      {c_sel, c_rd, c_rw, c_be, p_rd, p_be} = '0;
    end else if (!mem_pins.area_select_n) begin
      c_sel++;
      c_rd += !mem_pins.read_strobe_n;
      c_rw += !mem_pins.rd_wr_n;
      c_be += !(&mem_pins.byte_lane_strobe_n);
      p_rd += (c_rd == 0);
      p_be += (c_be == 0);
    end
  end

  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic int dec(logic [3:0] c);
    return c < 7 ? c : c == 7 ? 8 : c == 8 ? 10 : c == 9 ? 12 :
      c == 10 ? 14 : c == 11 ? 18 : 24;
  endfunction

  function automatic logic [31:0] wc(logic b, logic [2:0] w, logic [1:0] s,
    logic [3:0] r, logic m);
    return {11'h0, b, 1'b0, w, 3'h0, s, r, m, 6'h0};
  endfunction

  task automatic stop_test();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic waitfor(ref logic s);
    int n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (s !== 1'b1 && n < 300);
    if (s !== 1'b1) begin
      fails++;
      stop_test();
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    waitfor(pready);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic op(input logic w, input logic [5:0] a, input logic [31:0] d,
    input logic [3:0] b);
    clr <= 1;
    @(posedge pclk);
    clr <= 0;
    req <= '{1'b1, w, {18'h0, a}, d, b};
    waitfor(req_done);
    `CHK(req_busy, 1'b0)
    rdat = req_rdata;
    req.valid <= 0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic check(input logic w, input int wt);
    int s_len = 2 * sw + 1;
    int w_len = 2 * (wt + 1);
    if (w && bm && byte_access_strobe_select) begin
      `CHK(c_rw, w_len)
      `CHK(c_be, c_sel)
    end else if (w) begin
      `CHK(c_be, w_len)
      `CHK(p_be, s_len)
      `CHK(c_rw, c_sel)
    end else begin
      `CHK(c_rd, w_len)
      `CHK(p_rd, s_len)
      `CHK(c_be, bm ? (byte_access_strobe_select ? c_sel : c_rd) : 0)
    end
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, OFS_WAIT_CTRL, '0);
    `CHK(rd, 32'h0000_0500)
    apb(1, OFS_WAIT_CTRL, '1);
    apb(0, OFS_WAIT_CTRL, '0);
    `CHK(rd, 32'h0017_1fc0)
    apb(0, 12'h00c, '0);
    `CHK(er, 1'b1)
    {bm, byte_access_strobe_select, sw} = '0;
    stall <= 1;
    for (int m = 0; m < 2; m++) begin
      apb(1, OFS_WAIT_CTRL, wc(0, 3'h1, 2'h0, 4'h0, m[0]));
      op(0, 6'h0, '0, 4'hf);
      `CHK(c_rd > 2, m == 0)
    end
    stall <= 0;
    for (int i = 0; i < 30; i++) begin
      x = rnd();
      {bm, byte_access_strobe_select, ad, ww, sw} = x[12:0];
      wr = x[17:14] % 4'hd;
      be = x[21:18] == 0 ? 4'hf : x[21:18];
      if (i == 0) {ww, wr} = 7'h0c;
      apb(1, OFS_IF_CFG, {31'h0, bm});
      apb(1, OFS_WAIT_CTRL, wc(byte_access_strobe_select, ww, sw, wr, 1'b1));
      dt = rnd();
      op(1, ad, dt, be);
      check(1, ww == 0 ? dec(wr) : ww - 1);
      for (int l = 0; l < 4; l++)
        if (be[l]) shadow[ad][8*l +: 8] = dt[8*l +: 8];
      op(0, ad, '0, 4'hf);
      check(0, dec(wr));
      `CHK(rdat, shadow[ad])
    end
    apb(0, OFS_STATUS, '0);
    dt = {29'h0, 1'b1, bm && byte_access_strobe_select, 1'b0};
    `CHK(rd, dt)
    stop_test();
  end
endmodule
`undef CHK
`default_nettype wire
